//--- include/msi_consts.vh
// Purpose: constants for the motor start inhibit and re-acceleration supervisor
// Assumes: 50 MHz system clock, timers count whole milliseconds
// Notes:   offsets are byte addresses on a 32-bit APB bus
`ifndef MSI_CONSTS_VH
`define MSI_CONSTS_VH

`define MSI_CLK_NS        20
`define MSI_TICK_NS       1000000
`define MSI_TICK_CYCLES   (`MSI_TICK_NS / `MSI_CLK_NS)
`define MSI_TW            24
`define MSI_SLOTS         8
`define MSI_WATCH_S       5
`define MSI_WATCH_MS      (`MSI_WATCH_S * 1000)
`define MSI_FREEZE_MS     60000
`define MSI_COLD_MAX_PCT  8'h32
`define MSI_NUM_SAG_IN    5

`define MSI_OFF_CTRL      12'h000
`define MSI_OFF_LIMITS    12'h004
`define MSI_OFF_REF       12'h008
`define MSI_OFF_LOCKOUT   12'h00C
`define MSI_OFF_MININT    12'h010
`define MSI_OFF_REACC     12'h014
`define MSI_OFF_SUPERV    12'h018
`define MSI_OFF_MEDIUM    12'h01C
`define MSI_OFF_LONG      12'h020
`define MSI_OFF_VOLT      12'h024
`define MSI_OFF_STATUS    12'h028
`define MSI_OFF_EVENT     12'h02C

`define MSI_CTRL_RESTART  0
`define MSI_CTRL_INTVOLT  1
`define MSI_CTRL_TRIPMAP  2
`define MSI_CTRL_SEL_LO   4
`define MSI_CTRL_SEL_HI   6

`define MSI_RST_CTRL      32'h00000000
`define MSI_RST_LIMITS    32'h00000302
`define MSI_RST_TIME      24'h000000
`define MSI_RST_VOLT      32'h00000000

`endif

//--- core/msi_timer.v
// Purpose: millisecond down-counter used by every supervisory delay except the permitted-count freeze, which counts up
// Assumes: tickEn is a one-cycle pulse once per millisecond
// Notes:   a zero preset expires at the next tick
`timescale 1ns/1ps
`include "msi_consts.vh"
module msi_timer (
  input  wire                 clk_sys,
  input  wire                 resetn,
  input  wire                 tickEn,
  input  wire                 start,
  input  wire                 stop,
  input  wire [`MSI_TW-1:0]   preset,
  output reg                  running,
  output reg                  done
);
  reg [`MSI_TW-1:0] count;

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count   <= `MSI_RST_TIME;
      running <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count   <= preset;
        running <= 1'b1;
      end else if (stop) begin
        running <= 1'b0;
      end else if (running && tickEn) begin
        if (count <= {{(`MSI_TW-1){1'b0}}, 1'b1}) begin
          running <= 1'b0;
          done    <= 1'b1;
        end else begin
          count <= count - {{(`MSI_TW-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

//--- core/msi_top.v
// Purpose: start-count limit, minimum start interval, sag re-acceleration and auto restart
// Assumes: all status pins are asynchronous to clk_sys
// Notes:   registers on APB, zero wait states, every timer counts one common ms tick
`timescale 1ns/1ps
`include "msi_consts.vh"
// Operation
// - each start counted warm/cold while one of the 8 slots is free, expires after period
// - stop edge at limit starts lockout inhibit
// - inhibit held until counter drops below limit
// - thermal at or below 50% means cold
// - permitted count frozen at one when idle
// - every start restarts minimum-interval timer
// - early stop inhibits until interval timer ends
// - late stop raises no interval inhibit
// - sag from selected input or internal monitor
// - internal sag below under, restore above over
// - sag starts the re-acceleration window timer
// - restore plus stall current starts supervision
// - restore without stall current changes nothing
// - sag outlasting window raises sag timeout
// - auto restart arms only after sag trip
// - nonzero medium window starts after sag trip
// - restore within medium window gives close order
// - medium window expiry disarms auto restart
// - long delay extends restart when medium off
module msi_top #(
  parameter TICK_CYCLES = `MSI_TICK_CYCLES,
  parameter FREEZE_MS   = `MSI_FREEZE_MS,
  parameter VOLT_VARIANT = 1
) (
  input  wire                         clk_sys,
  input  wire                         resetn,
  input  wire                         psel,
  input  wire                         penable,
  input  wire                         pwrite,
  input  wire [11:0]                  paddr,
  input  wire [31:0]                  pwdata,
  output wire                         pready,
  output reg  [31:0]                  prdata,
  output reg                          pslverr,
  input  wire                         contactorPositionInput,
  input  wire                         startDetectIn,
  input  wire [7:0]                   thermalState,
  input  wire [`MSI_NUM_SAG_IN-1:0]   sagInputs,
  input  wire [15:0]                  voltageLevel,
  input  wire                         stallCurrentIn,
  output reg                          startCountInhibit,
  output reg                          minIntervalInhibit,
  output reg                          sagTimeout,
  output reg                          tripRelayOutput,
  output reg                          stallProtEnable,
  output reg                          startSupervision,
  output reg                          closeOrder
);
  localparam [3:0] RS_IDLE = 4'b0001;
  localparam [3:0] RS_MED  = 4'b0010;
  localparam [3:0] RS_WAIT = 4'b0100;
  localparam [3:0] RS_LONG = 4'b1000;
  localparam [31:0]        WATCH_WIDE    = `MSI_WATCH_MS;
  localparam [31:0]        FREEZE_WIDE   = FREEZE_MS;
  localparam [`MSI_TW-1:0] WATCH_PRESET  = WATCH_WIDE[`MSI_TW-1:0];
  localparam [`MSI_TW-1:0] FREEZE_LIMIT  = FREEZE_WIDE[`MSI_TW-1:0];
  localparam [31:0]        TICK_LAST     = TICK_CYCLES - 1;

  // register file
  reg [31:0]         ctrl;
  reg [31:0]         limits;
  reg [`MSI_TW-1:0]  refTime, lockTime, minTime, reaccTime, supTime, medTime, longTime;
  reg [31:0]         voltThr;
  reg [15:0]         eventCount;

  function isMapped;
    input [11:0] a;
    begin
      isMapped = (a[1:0] == 2'b00) && (a <= `MSI_OFF_EVENT);
    end
  endfunction

  assign pready = 1'b1;
  wire setupPhase = psel && !penable;
  wire wrAccess   = psel && penable && pwrite && isMapped(paddr);
  wire clearClose = wrAccess && (paddr == `MSI_OFF_EVENT) && pwdata[0];

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl      <= `MSI_RST_CTRL;
      limits    <= `MSI_RST_LIMITS;
      refTime   <= `MSI_RST_TIME;
      lockTime  <= `MSI_RST_TIME;
      minTime   <= `MSI_RST_TIME;
      reaccTime <= `MSI_RST_TIME;
      supTime   <= `MSI_RST_TIME;
      medTime   <= `MSI_RST_TIME;
      longTime  <= `MSI_RST_TIME;
      voltThr   <= `MSI_RST_VOLT;
    end else if (wrAccess) begin
      if (paddr == `MSI_OFF_CTRL) begin
        ctrl <= pwdata & 32'h00000077;
      end else if (paddr == `MSI_OFF_LIMITS) begin
        limits <= pwdata & 32'h00000F0F;
      end else if (paddr == `MSI_OFF_REF) begin
        refTime <= pwdata[`MSI_TW-1:0];
      end else if (paddr == `MSI_OFF_LOCKOUT) begin
        lockTime <= pwdata[`MSI_TW-1:0];
      end else if (paddr == `MSI_OFF_MININT) begin
        minTime <= pwdata[`MSI_TW-1:0];
      end else if (paddr == `MSI_OFF_REACC) begin
        reaccTime <= pwdata[`MSI_TW-1:0];
      end else if (paddr == `MSI_OFF_SUPERV) begin
        supTime <= pwdata[`MSI_TW-1:0];
      end else if (paddr == `MSI_OFF_MEDIUM) begin
        medTime <= pwdata[`MSI_TW-1:0];
      end else if (paddr == `MSI_OFF_LONG) begin
        longTime <= pwdata[`MSI_TW-1:0];
      end else if (paddr == `MSI_OFF_VOLT) begin
        voltThr <= pwdata;
      end
    end
  end

  // common ms tick
  reg [31:0] tickCnt;
  reg        tickEn;
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tickCnt <= 32'h00000000;
      tickEn  <= 1'b0;
    end else if (tickCnt >= TICK_LAST) begin
      tickCnt <= 32'h00000000;
      tickEn  <= 1'b1;
    end else begin
      tickCnt <= tickCnt + 32'h00000001;
      tickEn  <= 1'b0;
    end
  end

  // pin synchronisers; buses may skew by one sample, harmless for slow analog-derived levels
  localparam SW = 3 + `MSI_NUM_SAG_IN + 8 + 16;
  wire [SW-1:0] rawIn = {contactorPositionInput, startDetectIn, stallCurrentIn, sagInputs, thermalState,
                         voltageLevel};
  reg  [SW-1:0] syncA, syncB;
  reg           runPrev, startPrev;
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      syncA     <= {SW{1'b0}};
      syncB     <= {SW{1'b0}};
      runPrev   <= 1'b0;
      startPrev <= 1'b0;
    end else begin
      syncA     <= rawIn;
      syncB     <= syncA;
      runPrev   <= syncB[SW-1];
      startPrev <= syncB[SW-2];
    end
  end
  wire        motorRun  = syncB[SW-1];
  wire        stallNow  = syncB[SW-3];
  wire [4:0]  sagPins   = syncB[SW-4 -: `MSI_NUM_SAG_IN];
  wire [7:0]  thermal   = syncB[23:16];
  wire [15:0] volts     = syncB[15:0];
  wire startPulse = syncB[SW-2] && !startPrev;
  wire stopPulse  = runPrev && !motorRun;

  // start-count limitation with one reference timer per recorded start
  reg  [`MSI_SLOTS-1:0] slotWarm;
  wire [`MSI_SLOTS-1:0] slotRun, slotLoad;
  reg  [3:0]            warmCount, coldCount, freeIdx;
  integer i;
  always @* begin
    warmCount = 4'h0;
    coldCount = 4'h0;
    freeIdx   = 4'hF;
    for (i = `MSI_SLOTS - 1; i >= 0; i = i - 1) begin
      if (!slotRun[i]) begin
        freeIdx = i[3:0];
      end
      if (slotRun[i] && slotWarm[i]) begin
        warmCount = warmCount + 4'h1;
      end else if (slotRun[i]) begin
        coldCount = coldCount + 4'h1;
      end
    end
  end
  wire isWarm = thermal > `MSI_COLD_MAX_PCT;

  genvar g;
  generate
    for (g = 0; g < `MSI_SLOTS; g = g + 1) begin : refSlot
      assign slotLoad[g] = startPulse && (freeIdx == g);
      always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          slotWarm[g] <= 1'b0;
        end else if (slotLoad[g]) begin
          slotWarm[g] <= isWarm;
        end
      end
      msi_timer refTmr (
        .clk_sys(clk_sys), .resetn(resetn), .tickEn(tickEn), .start(slotLoad[g]), .stop(1'b0),
        .preset(refTime), .running(slotRun[g]), .done()
      );
    end
  endgenerate

  wire [3:0] warmLimit = limits[3:0];
  wire [3:0] coldLimit = limits[11:8];
  wire warmFull = (warmLimit != 4'h0) && (warmCount >= warmLimit);
  wire coldFull = (coldLimit != 4'h0) && (coldCount >= coldLimit);
  wire atLimit  = warmFull || coldFull;

  wire lockRun, lockDone;
  msi_timer lockTmr (
    .clk_sys(clk_sys), .resetn(resetn), .tickEn(tickEn), .start(stopPulse && atLimit), .stop(1'b0),
    .preset(lockTime), .running(lockRun), .done(lockDone)
  );

  reg holdExt;
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      holdExt <= 1'b0;
    end else if (lockDone && atLimit) begin
      holdExt <= 1'b1;
    end else if (!atLimit) begin
      holdExt <= 1'b0;
    end
  end

  // minimum interval between starts
  wire minRun, minDone;
  msi_timer minTmr (
    .clk_sys(clk_sys), .resetn(resetn), .tickEn(tickEn), .start(startPulse), .stop(1'b0),
    .preset(minTime), .running(minRun), .done(minDone)
  );
  reg minInh;
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      minInh <= 1'b0;
    end else begin
      minInh <= (minInh || (stopPulse && minRun)) && !minDone && !startPulse;
    end
  end

  // time since last start, drives the frozen permitted count
  reg [`MSI_TW-1:0] sinceStart;
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sinceStart <= `MSI_RST_TIME;
    end else if (startPulse) begin
      sinceStart <= `MSI_RST_TIME;
    end else if (tickEn && sinceStart <= FREEZE_LIMIT) begin
      sinceStart <= sinceStart + {{(`MSI_TW-1){1'b0}}, 1'b1};
    end
  end
  wire [3:0] remWarm = warmFull ? 4'h0 : (warmLimit - warmCount);
  wire [3:0] remCold = coldFull ? 4'h0 : (coldLimit - coldCount);
  wire [3:0] remMin  = (remWarm < remCold) ? remWarm : remCold;
  wire [3:0] permitted = (!atLimit && sinceStart > FREEZE_LIMIT) ? 4'h1 : remMin;

  // sag source and classification
  wire [2:0] sagSel  = ctrl[`MSI_CTRL_SEL_HI:`MSI_CTRL_SEL_LO];
  wire       useInt  = ctrl[`MSI_CTRL_INTVOLT] && (VOLT_VARIANT != 0);
  wire       extSag  = (sagSel < `MSI_NUM_SAG_IN) ? sagPins[sagSel] : 1'b0;
  reg        intSag;
  reg        sagPrev;
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      intSag <= 1'b0;
    end else if (volts < voltThr[15:0]) begin
      intSag <= 1'b1;
    end else if (volts > voltThr[31:16]) begin
      intSag <= 1'b0;
    end
  end
  wire sagNow  = useInt ? intSag : extSag;
  wire sagRise = sagNow && !sagPrev;
  wire sagFall = !sagNow && sagPrev;

  wire reaccRun, reaccDone, watchRun, supRun, supDone, medDone, longDone;
  msi_timer reaccTmr (
    .clk_sys(clk_sys), .resetn(resetn), .tickEn(tickEn), .start(sagRise), .stop(sagFall),
    .preset(reaccTime), .running(reaccRun), .done(reaccDone)
  );
  wire stallSeen = watchRun && stallNow;
  msi_timer watchTmr (
    .clk_sys(clk_sys), .resetn(resetn), .tickEn(tickEn), .start(sagFall && reaccRun), .stop(stallSeen),
    .preset(WATCH_PRESET), .running(watchRun), .done()
  );
  msi_timer supTmr (
    .clk_sys(clk_sys), .resetn(resetn), .tickEn(tickEn), .start(stallSeen), .stop(1'b0),
    .preset(supTime), .running(supRun), .done(supDone)
  );

  reg sagTrip;
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sagPrev <= 1'b0;
      sagTrip <= 1'b0;
    end else begin
      sagPrev <= sagNow;
      if (reaccDone && sagNow) begin
        sagTrip <= 1'b1;
      end else if (sagFall) begin
        sagTrip <= 1'b0;
      end
    end
  end
  wire tripRise = reaccDone && sagNow;

  // automatic restart sequencer
  reg [3:0] rsState;
  wire restartEn = ctrl[`MSI_CTRL_RESTART];
  wire medStart  = rsState[0] && tripRise && restartEn && (medTime != `MSI_RST_TIME);
  wire longStart = rsState[2] && sagFall;
  msi_timer medTmr (
    .clk_sys(clk_sys), .resetn(resetn), .tickEn(tickEn), .start(medStart), .stop(sagFall),
    .preset(medTime), .running(), .done(medDone)
  );
  msi_timer longTmr (
    .clk_sys(clk_sys), .resetn(resetn), .tickEn(tickEn), .start(longStart), .stop(1'b0),
    .preset(longTime), .running(), .done(longDone)
  );

  reg closeSet;
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rsState  <= RS_IDLE;
      closeSet <= 1'b0;
    end else begin
      closeSet <= 1'b0;
      if (!restartEn) begin
        rsState <= RS_IDLE;
      end else begin
        case (rsState)
          RS_IDLE: begin
            if (tripRise && medTime != `MSI_RST_TIME) begin
              rsState <= RS_MED;
            end else if (tripRise && longTime != `MSI_RST_TIME) begin
              rsState <= RS_WAIT;
            end
          end
          RS_MED: begin
            if (sagFall) begin
              closeSet <= 1'b1;
              rsState  <= RS_IDLE;
            end else if (medDone) begin
              rsState <= RS_IDLE;
            end
          end
          RS_WAIT: begin
            if (sagFall) begin
              rsState <= RS_LONG;
            end
          end
          RS_LONG: begin
            if (longDone) begin
              closeSet <= 1'b1;
              rsState  <= RS_IDLE;
            end
          end
          default: begin
            rsState <= RS_IDLE;
          end
        endcase
      end
    end
  end

  // registered outputs; close order stays until the motor runs or software clears it
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      startCountInhibit  <= 1'b0;
      minIntervalInhibit <= 1'b0;
      sagTimeout         <= 1'b0;
      tripRelayOutput    <= 1'b0;
      stallProtEnable    <= 1'b1;
      startSupervision   <= 1'b0;
      closeOrder         <= 1'b0;
      eventCount         <= 16'h0000;
    end else begin
      // lockDone bridges the one cycle before holdExt takes over, no gap in the inhibit
      startCountInhibit  <= lockRun || (lockDone && atLimit) || holdExt;
      minIntervalInhibit <= minInh;
      sagTimeout         <= sagTrip;
      tripRelayOutput    <= sagTrip && ctrl[`MSI_CTRL_TRIPMAP];
      stallProtEnable    <= !(supRun || stallSeen) || supDone;
      startSupervision   <= supRun || stallSeen;
      if (closeSet) begin
        closeOrder <= 1'b1;
        eventCount <= eventCount + 16'h0001;
      end else if (clearClose || motorRun) begin
        closeOrder <= 1'b0;
      end
    end
  end

  // read path: data sampled in setup phase, valid through access phase
  wire [31:0] status = {8'h00, rsState, permitted, coldCount, warmCount, 1'b0, sagNow, closeOrder,
                        stallProtEnable, sagTimeout, minIntervalInhibit, startCountInhibit, holdExt};
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      pslverr <= !isMapped(paddr);
      if (paddr == `MSI_OFF_CTRL) begin
        prdata <= ctrl;
      end else if (paddr == `MSI_OFF_LIMITS) begin
        prdata <= limits;
      end else if (paddr == `MSI_OFF_REF) begin
        prdata <= {8'h00, refTime};
      end else if (paddr == `MSI_OFF_LOCKOUT) begin
        prdata <= {8'h00, lockTime};
      end else if (paddr == `MSI_OFF_MININT) begin
        prdata <= {8'h00, minTime};
      end else if (paddr == `MSI_OFF_REACC) begin
        prdata <= {8'h00, reaccTime};
      end else if (paddr == `MSI_OFF_SUPERV) begin
        prdata <= {8'h00, supTime};
      end else if (paddr == `MSI_OFF_MEDIUM) begin
        prdata <= {8'h00, medTime};
      end else if (paddr == `MSI_OFF_LONG) begin
        prdata <= {8'h00, longTime};
      end else if (paddr == `MSI_OFF_VOLT) begin
        prdata <= voltThr;
      end else if (paddr == `MSI_OFF_STATUS) begin
        prdata <= status;
      end else if (paddr == `MSI_OFF_EVENT) begin
        prdata <= {16'h0000, eventCount};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end
endmodule

//--- testbench/msi_chk_sva.sv
// Purpose: port-level checks for the start inhibit and sag supervisor
// Assumes: one clock domain, resetn active low
// Notes:   look-back depths allow for the 2-flop input sync and edge detect
`timescale 1ns/1ps
module msi_chk (
  input wire clk_sys,
  input wire resetn,
  input wire contactorPositionInput,
  input wire stallCurrentIn,
  input wire startCountInhibit,
  input wire minIntervalInhibit,
  input wire sagTimeout,
  input wire tripRelayOutput,
  input wire stallProtEnable,
  input wire startSupervision,
  input wire closeOrder
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  count_inh_stop_a: assert property ($rose(startCountInhibit) |->
    !contactorPositionInput && !$past(contactorPositionInput, 3)) else $error("count inhibit without stop");
  min_int_stop_a: assert property ($rose(minIntervalInhibit) |->
    !contactorPositionInput && !$past(contactorPositionInput, 3)) else $error("interval inhibit without stop");
  superv_blocks_a: assert property (startSupervision && $past(startSupervision) |->
    !stallProtEnable) else $error("stall protection on during supervision");
  superv_cause_a: assert property ($rose(startSupervision) |-> $past(stallCurrentIn, 2) ||
    $past(stallCurrentIn, 3) || $past(stallCurrentIn, 4) || $past(stallCurrentIn, 5))
    else $error("supervision without stall current");
  stall_off_a: assert property ($fell(stallProtEnable) |-> startSupervision)
    else $error("stall protection dropped without supervision");
  stall_back_a: assert property ($fell(startSupervision) |-> ##[0:1] stallProtEnable)
    else $error("stall protection not restored");
  trip_follow_a: assert property (tripRelayOutput |-> sagTimeout || $past(sagTimeout))
    else $error("trip output without sag timeout");
  close_run_a: assert property (contactorPositionInput [*6] |-> !closeOrder)
    else $error("close order held while running");
endmodule

//--- testbench/msi_field.sv
// Purpose: contactor, start sensor, thermal, sag, voltage and current model
// Assumes: every pin changes just after a rising clk_sys edge
// Notes:   sensor pins are levels; the supervisor finds the edges itself
`timescale 1ns/1ps
module msi_field (
  input  wire        clk_sys,
  output reg         contactorPositionInput,
  output reg         startDetectIn,
  output reg  [7:0]  thermalState,
  output reg  [4:0]  sagInputs,
  output reg  [15:0] voltageLevel,
  output reg         stallCurrentIn
);
  initial {contactorPositionInput, startDetectIn, thermalState, sagInputs, stallCurrentIn} = 0;
  initial voltageLevel = 16'h012C;
  // start level held a few cycles so one rising edge means one start
  task start(input [7:0] th);
    @(posedge clk_sys);
    thermalState <= th;
    contactorPositionInput <= 1'b1;
    startDetectIn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    startDetectIn <= 1'b0;
  endtask
  task stop; @(posedge clk_sys) contactorPositionInput <= 1'b0; endtask
  task sag(input [4:0] v); @(posedge clk_sys) sagInputs <= v; endtask
  task volt(input [15:0] v); @(posedge clk_sys) voltageLevel <= v; endtask
  task stall(input v); @(posedge clk_sys) stallCurrentIn <= v; endtask
endmodule

//--- testbench/motor_start_inhibit_reaccel_test.sv
// Purpose: self-checking bench for the start inhibit and sag supervisor
// Assumes: 10-cycle ms tick and 20 ms freeze threshold keep the run short
// Notes:   field pins come from msi_field, registers over APB
`timescale 1ns/1ps
`include "msi_consts.vh"
`define CHK(n, e, g) begin totalChecks++; if ((g) !== (e)) begin failCount++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module motor_start_inhibit_reaccel_test;
  localparam TK = 10;
  reg         clk_sys;
  reg         resetn;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [11:0] paddr;
  reg  [31:0] pwdata;
  wire        pready;
  wire [31:0] prdata;
  wire        pslverr;
  wire        contactorPositionInput;
  wire        startDetectIn;
  wire [7:0]  thermalState;
  wire [4:0]  sagInputs;
  wire [15:0] voltageLevel;
  wire        stallCurrentIn;
  wire        startCountInhibit;
  wire        minIntervalInhibit;
  wire        sagTimeout;
  wire        tripRelayOutput;
  wire        stallProtEnable;
  wire        startSupervision;
  wire        closeOrder;
  reg  [31:0] rdv;
  reg         rerr;
  integer     failCount;
  integer     totalChecks;

  msi_top #(.TICK_CYCLES(TK), .FREEZE_MS(20), .VOLT_VARIANT(1)) DUT (
    .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .contactorPositionInput(contactorPositionInput), .startDetectIn(startDetectIn),
    .thermalState(thermalState), .sagInputs(sagInputs), .voltageLevel(voltageLevel),
    .stallCurrentIn(stallCurrentIn), .startCountInhibit(startCountInhibit),
    .minIntervalInhibit(minIntervalInhibit), .sagTimeout(sagTimeout), .tripRelayOutput(tripRelayOutput),
    .stallProtEnable(stallProtEnable), .startSupervision(startSupervision), .closeOrder(closeOrder));
  msi_field m (
    .clk_sys(clk_sys), .contactorPositionInput(contactorPositionInput), .startDetectIn(startDetectIn),
    .thermalState(thermalState), .sagInputs(sagInputs), .voltageLevel(voltageLevel),
    .stallCurrentIn(stallCurrentIn));

  initial begin
    clk_sys = 0;
    forever #10 clk_sys = ~clk_sys;
  end

  task completeRun;
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // the master waits for pready itself; a 20-cycle bound ends a wait that never sees it
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do begin @(posedge clk_sys); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin failCount++; completeRun; end
    rdv = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input [11:0] a, input [31:0] d); apb(1'b1, a, d); endtask
  task rd(input [11:0] a); apb(1'b0, a, 32'h00000000); endtask
  task ms(input integer n); repeat (n * TK) @(posedge clk_sys); endtask
  task cyc(input integer n); repeat (n) @(posedge clk_sys); endtask

  task tRegs;
    rd(`MSI_OFF_LIMITS);
    `CHK("limits", 32'h00000302, rdv)
    rd(`MSI_OFF_STATUS);
    `CHK("stallEn", 1'b1, rdv[4])
    `CHK("restartIdle", 4'h1, rdv[23:20])
    rd(12'h030);
    `CHK("unmapErr", 1'b1, rerr)
    `CHK("unmapData", 32'h00000000, rdv)
  endtask

  task tCount;
    wr(`MSI_OFF_LIMITS, 32'h00000102);
    wr(`MSI_OFF_REF, 32'h0000001E);
    wr(`MSI_OFF_LOCKOUT, 32'h00000005);
    wr(`MSI_OFF_MININT, 32'h00000000);
    m.start(8'h32);
    ms(1);
    rd(`MSI_OFF_STATUS);
    `CHK("coldCnt", 4'h1, rdv[15:12])
    `CHK("warmCnt", 4'h0, rdv[11:8])
    m.stop;
    cyc(10);
    `CHK("cntInhStop", 1'b1, startCountInhibit)
    `CHK("lateStop", 1'b0, minIntervalInhibit)
    ms(10);
    `CHK("cntInhHeld", 1'b1, startCountInhibit)
    ms(22);
    `CHK("cntInhEnd", 1'b0, startCountInhibit)
    rd(`MSI_OFF_STATUS);
    `CHK("coldExpired", 4'h0, rdv[15:12])
    m.start(8'h33);
    ms(1);
    rd(`MSI_OFF_STATUS);
    `CHK("warmCnt", 4'h1, rdv[11:8])
    m.stop;
    cyc(10);
    `CHK("belowLimit", 1'b0, startCountInhibit)
  endtask

  task tMin;
    wr(`MSI_OFF_LIMITS, 32'h00000000);
    wr(`MSI_OFF_MININT, 32'h0000000A);
    m.start(8'h00);
    ms(2);
    m.stop;
    cyc(10);
    `CHK("earlyStop", 1'b1, minIntervalInhibit)
    ms(4);
    `CHK("intHeld", 1'b1, minIntervalInhibit)
    ms(6);
    `CHK("intEnd", 1'b0, minIntervalInhibit)
    ms(10);
    rd(`MSI_OFF_STATUS);
    `CHK("permitted", 4'h1, rdv[19:16])
  endtask

  task tShort;
    wr(`MSI_OFF_REACC, 32'h0000000A);
    wr(`MSI_OFF_SUPERV, 32'h00000005);
    wr(`MSI_OFF_CTRL, 32'h00000020);
    m.sag(5'h04);
    ms(3);
    m.sag(5'h00);
    m.stall(1'b1);
    cyc(20);
    `CHK("superv", 1'b1, startSupervision)
    `CHK("stallOff", 1'b0, stallProtEnable)
    `CHK("noTimeout", 1'b0, sagTimeout)
    ms(6);
    `CHK("supervEnd", 1'b0, startSupervision)
    `CHK("stallOn", 1'b1, stallProtEnable)
    m.stall(1'b0);
    m.sag(5'h04);
    ms(3);
    m.sag(5'h00);
    ms(20);
    `CHK("noReaccel", 1'b0, startSupervision)
    `CHK("stallKept", 1'b1, stallProtEnable)
    m.sag(5'h02);
    ms(12);
    `CHK("unselected", 1'b0, sagTimeout)
    m.sag(5'h00);
  endtask

  task tLong;
    wr(`MSI_OFF_REACC, 32'h00000003);
    wr(`MSI_OFF_MEDIUM, 32'h0000000A);
    wr(`MSI_OFF_CTRL, 32'h00000025);
    m.sag(5'h04);
    ms(2);
    `CHK("windowOpen", 1'b0, sagTimeout)
    ms(3);
    `CHK("sagTimeout", 1'b1, sagTimeout)
    `CHK("trip", 1'b1, tripRelayOutput)
    rd(`MSI_OFF_STATUS);
    `CHK("medium", 4'h2, rdv[23:20])
    m.sag(5'h00);
    cyc(10);
    `CHK("close", 1'b1, closeOrder)
    rd(`MSI_OFF_EVENT);
    `CHK("events", 16'h0001, rdv[15:0])
    wr(`MSI_OFF_EVENT, 32'h00000001);
    m.sag(5'h04);
    ms(16);
    rd(`MSI_OFF_STATUS);
    `CHK("disarmed", 4'h1, rdv[23:20])
    m.sag(5'h00);
    cyc(10);
    `CHK("noClose", 1'b0, closeOrder)
    wr(`MSI_OFF_MEDIUM, 32'h00000000);
    wr(`MSI_OFF_LONG, 32'h00000004);
    m.sag(5'h04);
    ms(5);
    rd(`MSI_OFF_STATUS);
    `CHK("waitRestore", 4'h4, rdv[23:20])
    m.sag(5'h00);
    ms(2);
    `CHK("shedEarly", 1'b0, closeOrder)
    ms(4);
    `CHK("shedClose", 1'b1, closeOrder)
    m.start(8'h00);
    cyc(10);
    `CHK("closeClr", 1'b0, closeOrder)
  endtask

  task tVolt;
    wr(`MSI_OFF_VOLT, 32'h00C80064);
    wr(`MSI_OFF_CTRL, 32'h00000002);
    m.volt(16'h0032);
    cyc(10);
    rd(`MSI_OFF_STATUS);
    `CHK("underSag", 1'b1, rdv[6])
    m.volt(16'h0096);
    cyc(10);
    rd(`MSI_OFF_STATUS);
    `CHK("hysteresis", 1'b1, rdv[6])
    m.volt(16'h00FA);
    cyc(10);
    rd(`MSI_OFF_STATUS);
    `CHK("restored", 1'b0, rdv[6])
  endtask

  initial begin
    failCount = 0;
    totalChecks = 0;
    {resetn, psel, penable, pwrite, paddr, pwdata} = 0;
    repeat (5) @(posedge clk_sys);
    resetn <= 1;
    tRegs;
    tCount;
    tMin;
    tShort;
    tLong;
    tVolt;
    completeRun;
  end
endmodule

bind msi_top msi_chk chk (
  .clk_sys(clk_sys), .resetn(resetn), .contactorPositionInput(contactorPositionInput),
  .stallCurrentIn(stallCurrentIn), .startCountInhibit(startCountInhibit),
  .minIntervalInhibit(minIntervalInhibit), .sagTimeout(sagTimeout), .tripRelayOutput(tripRelayOutput),
  .stallProtEnable(stallProtEnable), .startSupervision(startSupervision), .closeOrder(closeOrder));
